// ===== verilog/alm_core.sv
// Execution unit for OR, move, no-op, return and rotate instructions
// Operation
// - OR-with-literal ORs the accumulator with k into the accumulator, Z only.
// - Load-literal puts k in the accumulator and touches no flag.
// - OR-with-file ORs the accumulator with file f and updates Z.
// - Destination bit 0 writes the accumulator, 1 writes file f back.
// - Store-accumulator copies the accumulator into file f, flags unchanged.
// - Move-file copies file f to the destination and always updates Z.
// - Return-from-interrupt pops the stack into PC and sets the enable.
// - Return-with-literal loads k, pops the stack, keeps flags, two cycles.
// - Rotate-left moves carry into bit 0 and bit 7 into carry.
// - Rotate-right moves carry into bit 7 and bit 0 into carry.
`timescale 1ns/1ps
`include "alm_regs.svh"
module alm_core
    import alm_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Instruction issue
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    // File register read data, combinational for instr[6:0]
    input  wire logic [7:0]  file_rdata,
    // Return stack
    input  wire logic [12:0] top_of_return_stack,
    // Flags and state
    output logic             zero_flag,
    output logic             carry_flag,
    output logic             global_interrupt_enable,
    output logic [7:0]       acc,
    output logic [12:0]      pc,
    // File register write
    output logic             file_we,
    output logic [6:0]       file_waddr,
    output logic [7:0]       file_wdata,
    // Stack pop and pipeline status
    output logic             stack_pop,
    output logic             busy
);
    import alm_pkg::*;

    alm_op_t    op;
    alm_state_t state_q;
    logic       exec;
    logic       dest;
    logic [7:0] lit;
    logic [7:0] result;
    logic       wr_acc;
    logic       wr_file;
    logic       upd_z;
    logic       upd_c;
    logic       new_c;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction

    alm_decode u_decode (
        .instr (instr),
        .op    (op)
    );

    // Instruction taken only outside the flush cycle of a return
    assign exec = instr_valid && (state_q == ALM_ST_EXEC);
    assign dest = instr[`ALM_DEST_BIT];
    assign lit  = instr[7:0];

    always_comb begin
        result  = 8'h00;
        wr_acc  = 1'b0;
        wr_file = 1'b0;
        upd_z   = 1'b0;
        upd_c   = 1'b0;
        new_c   = carry_flag;
        case (op)
            ALM_OP_OR_LIT: begin
                result = acc | lit;
                wr_acc = 1'b1;
                upd_z  = 1'b1;
            end
            ALM_OP_LOAD_LIT, ALM_OP_RET_LIT: begin
                result = lit;
                wr_acc = 1'b1;
            end
            ALM_OP_OR_FILE: begin
                result  = acc | file_rdata;
                wr_acc  = !dest;
                wr_file = dest;
                upd_z   = 1'b1;
            end
            ALM_OP_STORE: begin
                result  = acc;
                wr_file = 1'b1;
            end
            ALM_OP_MOVE_FILE: begin
                result  = file_rdata;
                wr_acc  = !dest;
                wr_file = dest;
                upd_z   = 1'b1;
            end
            ALM_OP_ROT_LEFT: begin
                result  = {file_rdata[6:0], carry_flag};
                new_c   = file_rdata[7];
                wr_acc  = !dest;
                wr_file = dest;
                upd_c   = 1'b1;
            end
            ALM_OP_ROT_RIGHT: begin
                result  = {carry_flag, file_rdata[7:1]};
                new_c   = file_rdata[0];
                wr_acc  = !dest;
                wr_file = dest;
                upd_c   = 1'b1;
            end
            // Unsupported words and no-op leave all state but the PC alone
            default: begin
                result = 8'h00;
            end
        endcase
    end

    // Two-cycle returns: second cycle is a flush with no effect
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_q <= ALM_ST_EXEC;
        end else begin
            case (state_q)
                ALM_ST_EXEC: begin
                    if (exec && (op == ALM_OP_RET_LIT ||
                                 op == ALM_OP_RET_IRQ)) begin
                        state_q <= ALM_ST_FLUSH;
                    end
                end
                ALM_ST_FLUSH: state_q <= ALM_ST_EXEC;
                default:      state_q <= ALM_ST_EXEC;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else begin
            busy <= exec && (op == ALM_OP_RET_LIT || op == ALM_OP_RET_IRQ);
        end
    end

    // Accumulator
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            acc <= `ALM_ACC_RST;
        end else if (exec && wr_acc) begin
            acc <= result;
        end
    end

    // Zero and carry flags
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            zero_flag  <= 1'b0;
            carry_flag <= 1'b0;
        end else if (exec) begin
            if (upd_z) begin
                zero_flag <= is_zero(result);
            end
            if (upd_c) begin
                carry_flag <= new_c;
            end
        end
    end

    // File write port, registered one cycle after execution
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            file_we    <= 1'b0;
            file_waddr <= 7'h00;
            file_wdata <= 8'h00;
        end else begin
            file_we <= exec && wr_file;
            if (exec && wr_file) begin
                file_waddr <= instr[`ALM_FADDR_MSB:0];
                file_wdata <= result;
            end
        end
    end

    // Program counter and stack pop
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pc        <= `ALM_PC_RST;
            stack_pop <= 1'b0;
        end else begin
            stack_pop <= 1'b0;
            if (exec && (op == ALM_OP_RET_LIT ||
                         op == ALM_OP_RET_IRQ)) begin
                pc        <= top_of_return_stack;
                stack_pop <= 1'b1;
            end else if (exec) begin
                pc <= pc + 13'h0001;
            end
        end
    end

    // Global interrupt enable, only set here
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            global_interrupt_enable <= 1'b0;
        end else if (exec && op == ALM_OP_RET_IRQ) begin
            global_interrupt_enable <= 1'b1;
        end
    end
endmodule

// ===== verilog/alm_regs.svh
// Opcode encodings, field positions and reset values of the execution unit
`ifndef ALM_REGS_SVH
`define ALM_REGS_SVH

`define ALM_OP_W           14
`define ALM_DEST_BIT       7
`define ALM_FADDR_MSB      6
`define ALM_PC_W           13
`define ALM_PC_RST         13'h0000
`define ALM_ACC_RST        8'h00
`define ALM_RET_CYCLES     2

// Exact words
`define ALM_NO_OP_WORD     14'h0000
`define ALM_RET_IRQ_WORD   14'h0009
// Upper bits of byte-immediate forms
`define ALM_OR_LIT_HI      6'h38
`define ALM_RET_LIT_HI     4'hd
`define ALM_LOAD_LIT_HI    4'hc
// Upper bits of file forms, bits 13:8, store bits 13:7
`define ALM_OR_FILE_HI     6'h04
`define ALM_MOVE_FILE_HI   6'h08
`define ALM_ROT_RIGHT_HI   6'h0c
`define ALM_ROT_LEFT_HI    6'h0d
`define ALM_STORE_HI       7'h01

`endif

// ===== verilog/alm_pkg.sv
// Types shared by the execution unit and its decoder
package alm_pkg;
    typedef enum logic [3:0] {
        ALM_OP_NONE        = 4'h0,
        ALM_OP_NO_OP       = 4'h1,
        ALM_OP_OR_LIT      = 4'h2,
        ALM_OP_LOAD_LIT    = 4'h3,
        ALM_OP_OR_FILE     = 4'h4,
        ALM_OP_STORE       = 4'h5,
        ALM_OP_MOVE_FILE   = 4'h6,
        ALM_OP_RET_IRQ     = 4'h7,
        ALM_OP_RET_LIT     = 4'h8,
        ALM_OP_ROT_LEFT    = 4'h9,
        ALM_OP_ROT_RIGHT   = 4'ha
    } alm_op_t;

    typedef enum logic [1:0] {
        ALM_ST_EXEC  = 2'b00,
        ALM_ST_FLUSH = 2'b01
    } alm_state_t;
endpackage

// ===== verilog/alm_decode.sv
// Opcode classifier for the supported instruction words
`timescale 1ns/1ps
`include "alm_regs.svh"
module alm_decode
    import alm_pkg::*;
(
    // Instruction in
    input  wire logic [13:0] instr,
    // Classified operation
    output alm_pkg::alm_op_t op
);
    always_comb begin
        op = ALM_OP_NONE;
        if (instr == `ALM_NO_OP_WORD) begin
            op = ALM_OP_NO_OP;
        end else if (instr == `ALM_RET_IRQ_WORD) begin
            op = ALM_OP_RET_IRQ;
        end else if (instr[13:8] == `ALM_OR_LIT_HI) begin
            op = ALM_OP_OR_LIT;
        end else if (instr[13:10] == `ALM_RET_LIT_HI) begin
            op = ALM_OP_RET_LIT;
        end else if (instr[13:10] == `ALM_LOAD_LIT_HI) begin
            op = ALM_OP_LOAD_LIT;
        end else if (instr[13:7] == `ALM_STORE_HI) begin
            op = ALM_OP_STORE;
        end else begin
            case (instr[13:8])
                `ALM_OR_FILE_HI:   op = ALM_OP_OR_FILE;
                `ALM_MOVE_FILE_HI: op = ALM_OP_MOVE_FILE;
                `ALM_ROT_RIGHT_HI: op = ALM_OP_ROT_RIGHT;
                `ALM_ROT_LEFT_HI:  op = ALM_OP_ROT_LEFT;
                default:           op = ALM_OP_NONE;
            endcase
        end
    end
endmodule

// ===== testbench/alm_core_chk.sv
// Port assertions for the execution unit
`timescale 1ns/1ps
module alm_core_chk (
    input wire logic        ref_clk, srst, instr_valid, busy,
    input wire logic [13:0] instr,
    input wire logic [7:0]  acc, file_wdata,
    input wire logic [12:0] top_of_return_stack, pc,
    input wire logic        zero_flag, file_we, stack_pop,
    input wire logic        global_interrupt_enable,
    input wire logic [6:0]  file_waddr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic tk = instr_valid && !busy;
    chk_pop_flush: assert property (stack_pop |-> busy ##1 !busy)
        else $error("flush");
    chk_pop_pc: assert property (
        stack_pop |-> pc == $past(top_of_return_stack)) else $error("pc");
    chk_irq_en_set: assert property (
        $rose(global_interrupt_enable) |-> stack_pop)
        else $error("irq enable");
    chk_rot_keep_z: assert property (tk && instr[13:9] == 5'h06 |=>
        $stable(zero_flag)) else $error("rotate z");
    chk_or_lit: assert property (tk && instr[13:8] == 6'h38 |=>
        acc == ($past(acc) | $past(instr[7:0])) && zero_flag == (acc == 0))
        else $error("or");
    chk_load_lit: assert property (tk && instr[13:10] == 4'hc |=>
        acc == $past(instr[7:0]) && $stable(zero_flag)) else $error("ld");
    chk_store_copy: assert property (tk && instr[13:7] == 7'h01 |=>
        file_we && file_wdata == $past(acc)
        && file_waddr == $past(instr[6:0])) else $error("st");
    chk_nop_idle: assert property (tk && instr == 14'h0000 |=>
        $stable(acc) && !file_we && pc == $past(pc) + 13'h0001)
        else $error("nop");
    chk_busy_refuse: assert property (busy |=>
        $stable(acc) && !file_we && !stack_pop) else $error("busy");
endmodule

bind alm_core alm_core_chk chk_i (.ref_clk, .srst, .instr_valid, .busy,
    .instr, .acc, .file_wdata, .top_of_return_stack, .pc, .zero_flag,
    .file_we, .stack_pop, .global_interrupt_enable, .file_waddr);

// ===== testbench/alm_mem_model.sv
// File register space on the far side of the execution unit
`timescale 1ns/1ps
module alm_mem_model (
    input  wire logic       ref_clk,
    input  wire logic [6:0] addr,
    output logic      [7:0] rdata,
    input  wire logic       we,
    input  wire logic [6:0] waddr,
    input  wire logic [7:0] wdata
);
    logic [7:0] mem [128];
    // Forward the late write so a following read sees it
    assign rdata = (we && waddr == addr) ? wdata : mem[addr];
    always @(posedge ref_clk)
        if (we) mem[waddr] <= wdata;
endmodule

// ===== testbench/accumulator_logic_move_return_ops_tb.sv
// Random instruction stream against a reference model
`timescale 1ns/1ps
module accumulator_logic_move_return_ops_tb;
    logic        ref_clk = 0, srst = 1, instr_valid = 0;
    logic [13:0] instr = 14'h0000;
    logic [12:0] ret_addr = 13'h0000, pc;
    logic [7:0]  file_rdata, acc, file_wdata;
    logic [6:0]  file_waddr;
    logic        zero_flag, carry_flag, irq_en, file_we, stack_pop, busy;
    int          err_count = 0, checked = 0;
    int          m_acc, m_z, m_c, m_irq_en, m_pc, mem [128];
    localparam logic [13:0] BASE [10] = '{14'h0000, 14'h0009, 14'h3800,
        14'h3400, 14'h3000, 14'h0080, 14'h0400, 14'h0800, 14'h0c00, 14'h0d00};

    always #4 ref_clk = ~ref_clk;

    alm_core dut (.ref_clk, .srst, .instr_valid, .instr, .file_rdata,
        .top_of_return_stack(ret_addr), .zero_flag, .carry_flag,
        .global_interrupt_enable(irq_en), .acc, .pc, .file_we, .file_waddr,
        .file_wdata, .stack_pop, .busy);
    alm_mem_model mem_i (.ref_clk, .addr(instr[6:0]), .rdata(file_rdata),
        .we(file_we), .waddr(file_waddr), .wdata(file_wdata));

    task automatic cmp(input string n, input logic [15:0] e, g);
        checked++;
        if (e !== g) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_state;
        cmp("acc", m_acc, acc);
        cmp("zero", m_z, zero_flag);
        cmp("carry", m_c, carry_flag);
        cmp("irq_en", m_irq_en, irq_en);
        cmp("pc", m_pc, pc);
    endtask

    task automatic end_sim;
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic exec(input logic [13:0] w);
        int v, r, f, d, k, wr, ret, t;
        f = w[6:0];
        d = w[7];
        k = w[7:0];
        v = mem[f];
        r = -1;
        wr = 0;
        ret = (w == 14'h0009) || (w[13:10] == 4'hd);
        t = $urandom & 32'h1fff;
        @(posedge ref_clk);
        instr <= w;
        instr_valid <= 1;
        ret_addr <= t[12:0];
        if (w == 14'h0009) m_irq_en = 1;
        else if (w[13:11] == 3'h6) m_acc = k;
        else if (w[13:8] == 6'h38) begin
            m_acc |= k;
            m_z = m_acc == 0;
        end else if (w[13:7] == 7'h01) begin
            mem[f] = m_acc;
            wr = 1;
        end else if (w[13:8] == 6'h04) r = m_acc | v;
        else if (w[13:8] == 6'h08) r = v;
        else if (w[13:8] == 6'h0c) begin
            r = {m_c[0], v[7:1]};
            m_c = v & 1;
        end else if (w[13:8] == 6'h0d) begin
            r = {v[6:0], m_c[0]};
            m_c = v[7];
        end
        if (r >= 0) begin
            if (w[13:9] != 5'h06) m_z = r == 0;
            if (d) mem[f] = r;
            else m_acc = r;
            wr = d;
        end
        m_pc = ret ? t : (m_pc + 1) & 32'h1fff;
        @(posedge ref_clk);
        // Offered during the flush, must be ignored
        instr <= 14'h30a5;
        instr_valid <= ret[0];
        #1;
        cmp_state;
        cmp("we", wr, file_we);
        if (wr) cmp("waddr", f, file_waddr);
        if (wr) cmp("wdata", mem[f], file_wdata);
        cmp("pop", ret, stack_pop);
        cmp("busy", ret, busy);
        if (ret) begin
            @(posedge ref_clk);
            instr_valid <= 0;
            #1;
            cmp_state;
            cmp("busy", 0, busy);
        end
    endtask

    initial begin
        int w;
        void'($urandom(32'hf35f));
        for (int i = 0; i < 128; i++) begin
            mem[i] = $urandom % 2 ? $urandom & 255 : 0;
            mem_i.mem[i] = mem[i][7:0];
        end
        repeat (4) @(posedge ref_clk);
        srst <= 0;
        @(posedge ref_clk);
        #1;
        cmp_state;
        for (int i = 0; i < 400; i++) begin
            w = BASE[$urandom % 10];
            if (w > 9) w |= $urandom % 3 ? $urandom & 255 : 0;
            exec(w[13:0]);
        end
        end_sim;
    end

    initial begin
        #40000;
        err_count++;
        end_sim;
    end
endmodule
